// File: design/ssxa_pkg.sv
// Package of constants and types for the subtract, swap and xor datapath
// ----------------------------------------------------------------------
// Function
// - Subtract-acc-from-file computes file minus accumulator; file address limited 0..127.
// - Destination bit 0 writes accumulator, 1 writes back to addressed file register.
// - Subtract updates carry, nibble borrow, zero; carry clear when acc exceeds file.
// - Subtract-with-borrow computes file minus acc minus inverted carry, routed by destination.
// - Nibble exchange swaps file halves into result; flags unchanged.
// - Xor literal into acc with 8-bit immediate; result to acc, zero only.
// - Direction load copies acc to port A, B, C direction for operand 5, 6, 7.
// - Xor acc with file, routed by destination bit, updates only zero.
// ----------------------------------------------------------------------
package ssxa_pkg;

  localparam int          DATA_W      = 8;
  localparam int          ADDR_W      = 7;
  localparam logic [6:0]  FILE_MAX    = 7'h7f;
  localparam logic [2:0]  DIR_SEL_A   = 3'h5;
  localparam logic [2:0]  DIR_SEL_B   = 3'h6;
  localparam logic [2:0]  DIR_SEL_C   = 3'h7;
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [7:0]  DIR_RESET   = 8'hff;
  localparam logic        FLAG_RESET  = 1'b0;
  localparam logic        DEST_ACC    = 1'b0;
  localparam logic        DEST_FILE   = 1'b1;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_SUBTRACT_ACC_FROM_FILE,
    OP_SUBTRACT_WITH_BORROW,
    OP_NIBBLE_EXCHANGE,
    OP_XOR_LITERAL_INTO_ACC,
    OP_XOR_ACC_WITH_FILE,
    OP_PIN_DIRECTION_LOAD
  } ssxa_op_t;

endpackage

// File: design/ssxa_flag_if.sv
// Interface carrying the arithmetic result and flag outcome
`timescale 1ns/1ns
interface ssxa_flag_if;
  logic [7:0] result;
  logic       carryOut;
  logic       nibbleBorrowOut;
  logic       zeroOut;
  modport producer (output result, output carryOut, output nibbleBorrowOut, output zeroOut);
  modport consumer (input result, input carryOut, input nibbleBorrowOut, input zeroOut);
endinterface

// File: design/ssxa_alu_core.sv
// Combinational arithmetic core for the six operations
`timescale 1ns/1ns
module ssxa_alu_core (
  // Operation and operands
  input  wire ssxa_pkg::ssxa_op_t op,
  input  wire logic [7:0]         accVal,
  input  wire logic [7:0]         fileVal,
  input  wire logic [7:0]         literal,
  input  wire logic               carryIn,
  // Result
  ssxa_flag_if.producer           res
);

  logic [8:0] fullDiff;
  logic [4:0] lowDiff;
  logic       borrowIn;

  always_comb begin
    borrowIn = (op == ssxa_pkg::OP_SUBTRACT_WITH_BORROW) ? ~carryIn : 1'b0;
    // Carry in 9-bit add of inverted acc: set means no borrow
    fullDiff = {1'b0, fileVal} + {1'b0, ~accVal} + {8'h00, ~borrowIn};
    lowDiff  = {1'b0, fileVal[3:0]} + {1'b0, ~accVal[3:0]} + {4'h0, ~borrowIn};
    res.carryOut        = fullDiff[8];
    res.nibbleBorrowOut = lowDiff[4];
    case (op)
      ssxa_pkg::OP_SUBTRACT_ACC_FROM_FILE,
      ssxa_pkg::OP_SUBTRACT_WITH_BORROW: res.result = fullDiff[7:0];
      ssxa_pkg::OP_NIBBLE_EXCHANGE:      res.result = {fileVal[3:0], fileVal[7:4]};
      ssxa_pkg::OP_XOR_LITERAL_INTO_ACC: res.result = accVal ^ literal;
      ssxa_pkg::OP_XOR_ACC_WITH_FILE:    res.result = accVal ^ fileVal;
      ssxa_pkg::OP_PIN_DIRECTION_LOAD:   res.result = accVal;
      default:                           res.result = 8'h00;
    endcase
    res.zeroOut = (res.result == 8'h00);
  end

endmodule // ssxa_alu_core

// File: design/ssxa_datapath.sv
// Top of the subtract, swap, xor and direction-load datapath
`timescale 1ns/1ns
module ssxa_datapath (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  // Decoded instruction
  input  wire logic               instValid,
  input  wire ssxa_pkg::ssxa_op_t instOp,
  input  wire logic [6:0]         fileAddr,
  input  wire logic               destBit,
  input  wire logic [7:0]         literal,
  // Register file read port
  input  wire logic [7:0]         fileRdData,
  // Register file write port
  output logic                    fileWrEn,
  output logic [6:0]              fileWrAddr,
  output logic [7:0]              fileWrData,
  // Architectural state
  output logic [7:0]              accOut,
  output logic                    carryFlag,
  output logic                    nibbleBorrowFlag,
  output logic                    zeroFlag,
  output logic [7:0]              portADirection,
  output logic [7:0]              portBDirection,
  output logic [7:0]              portCDirection
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rstMeta_q;
  logic rstSync_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // Arithmetic core
  // ----------------------------------------------------------------
  ssxa_flag_if aluRes ();

  logic [7:0] acc_q,   acc_d;
  logic       carry_q, carry_d;
  logic       nib_q,   nib_d;
  logic       zero_q,  zero_d;
  logic [7:0] dirA_q,  dirA_d;
  logic [7:0] dirB_q,  dirB_d;
  logic [7:0] dirC_q,  dirC_d;
  logic       wrEn_q,  wrEn_d;
  logic [6:0] wrAddr_q, wrAddr_d;
  logic [7:0] wrData_q, wrData_d;

  ssxa_alu_core uCore (
    .op      (instOp),
    .accVal  (acc_q),
    .fileVal (fileRdData),
    .literal (literal),
    .carryIn (carry_q),
    .res     (aluRes.producer)
  );

  function automatic logic usesDest(input ssxa_pkg::ssxa_op_t o);
    usesDest = (o == ssxa_pkg::OP_SUBTRACT_ACC_FROM_FILE) || (o == ssxa_pkg::OP_SUBTRACT_WITH_BORROW) ||
               (o == ssxa_pkg::OP_NIBBLE_EXCHANGE) || (o == ssxa_pkg::OP_XOR_ACC_WITH_FILE);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    acc_d    = acc_q;
    carry_d  = carry_q;
    nib_d    = nib_q;
    zero_d   = zero_q;
    dirA_d   = dirA_q;
    dirB_d   = dirB_q;
    dirC_d   = dirC_q;
    wrEn_d   = 1'b0;
    wrAddr_d = wrAddr_q;
    wrData_d = wrData_q;
    if (instValid) begin
      if (usesDest(instOp)) begin
        if (destBit == ssxa_pkg::DEST_FILE) begin
          wrEn_d   = 1'b1;
          wrAddr_d = fileAddr & ssxa_pkg::FILE_MAX;
          wrData_d = aluRes.result;
        end else begin
          acc_d = aluRes.result;
        end
      end
      case (instOp)
        ssxa_pkg::OP_SUBTRACT_ACC_FROM_FILE,
        ssxa_pkg::OP_SUBTRACT_WITH_BORROW: begin
          carry_d = aluRes.carryOut;
          nib_d   = aluRes.nibbleBorrowOut;
          zero_d  = aluRes.zeroOut;
        end
        ssxa_pkg::OP_XOR_LITERAL_INTO_ACC: begin
          acc_d  = aluRes.result;
          zero_d = aluRes.zeroOut;
        end
        ssxa_pkg::OP_XOR_ACC_WITH_FILE: begin
          zero_d = aluRes.zeroOut;
        end
        ssxa_pkg::OP_PIN_DIRECTION_LOAD: begin
          if (fileAddr[2:0] == ssxa_pkg::DIR_SEL_A && fileAddr[6:3] == 4'h0) begin
            dirA_d = acc_q;
          end else if (fileAddr[2:0] == ssxa_pkg::DIR_SEL_B && fileAddr[6:3] == 4'h0) begin
            dirB_d = acc_q;
          end else if (fileAddr[2:0] == ssxa_pkg::DIR_SEL_C && fileAddr[6:3] == 4'h0) begin
            dirC_d = acc_q;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      acc_q    <= ssxa_pkg::ACC_RESET;
      carry_q  <= ssxa_pkg::FLAG_RESET;
      nib_q    <= ssxa_pkg::FLAG_RESET;
      zero_q   <= ssxa_pkg::FLAG_RESET;
      dirA_q   <= ssxa_pkg::DIR_RESET;
      dirB_q   <= ssxa_pkg::DIR_RESET;
      dirC_q   <= ssxa_pkg::DIR_RESET;
      wrEn_q   <= 1'b0;
      wrAddr_q <= 7'h00;
      wrData_q <= 8'h00;
    end else begin
      acc_q    <= acc_d;
      carry_q  <= carry_d;
      nib_q    <= nib_d;
      zero_q   <= zero_d;
      dirA_q   <= dirA_d;
      dirB_q   <= dirB_d;
      dirC_q   <= dirC_d;
      wrEn_q   <= wrEn_d;
      wrAddr_q <= wrAddr_d;
      wrData_q <= wrData_d;
    end
  end

  assign fileWrEn         = wrEn_q;
  assign fileWrAddr       = wrAddr_q;
  assign fileWrData       = wrData_q;
  assign accOut           = acc_q;
  assign carryFlag        = carry_q;
  assign nibbleBorrowFlag = nib_q;
  assign zeroFlag         = zero_q;
  assign portADirection   = dirA_q;
  assign portBDirection   = dirB_q;
  assign portCDirection   = dirC_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSync_q);

  sequence s_subIssue;
    instValid && instOp == ssxa_pkg::OP_SUBTRACT_ACC_FROM_FILE;
  endsequence

  property p_subValue;
    (s_subIssue and (destBit == 1'b0)) |=> acc_q == 8'($past(fileRdData) - $past(acc_q));
  endproperty
  a_subValue: assert property (p_subValue) else $error("Subtract result wrong");

  property p_destFile;
    instValid && usesDest(instOp) && destBit |=> wrEn_q && acc_q == $past(acc_q);
  endproperty
  a_destFile: assert property (p_destFile) else $error("File destination not honoured");

  property p_subCarry;
    s_subIssue |=> carry_q == ($past(acc_q) <= $past(fileRdData)) &&
                   nib_q == ($past(acc_q[3:0]) <= $past(fileRdData[3:0]));
  endproperty
  a_subCarry: assert property (p_subCarry) else $error("Subtract carry wrong");

  property p_sbbValue;
    instValid && instOp == ssxa_pkg::OP_SUBTRACT_WITH_BORROW && !destBit |=>
      acc_q == 8'($past(fileRdData) - $past(acc_q) - {7'h00, ~$past(carry_q)});
  endproperty
  a_sbbValue: assert property (p_sbbValue) else $error("Borrow subtract wrong");

  property p_sbbCarry;
    instValid && instOp == ssxa_pkg::OP_SUBTRACT_WITH_BORROW |=>
      carry_q == ({1'b0, $past(fileRdData)} >= ({1'b0, $past(acc_q)} + {8'h00, ~$past(carry_q)})) &&
      nib_q == ({1'b0, $past(fileRdData[3:0])} >= ({1'b0, $past(acc_q[3:0])} + {4'h0, ~$past(carry_q)}));
  endproperty
  a_sbbCarry: assert property (p_sbbCarry) else $error("Borrow subtract flags wrong");

  property p_swap;
    instValid && instOp == ssxa_pkg::OP_NIBBLE_EXCHANGE |=>
      $stable({carry_q, nib_q, zero_q}) &&
      ($past(destBit) ? wrData_q : acc_q) == {$past(fileRdData[3:0]), $past(fileRdData[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("Nibble exchange wrong");

  property p_xorLit;
    instValid && instOp == ssxa_pkg::OP_XOR_LITERAL_INTO_ACC |=>
      acc_q == ($past(acc_q) ^ $past(literal)) && $stable(carry_q) &&
      zero_q == (($past(acc_q) ^ $past(literal)) == 8'h00);
  endproperty
  a_xorLit: assert property (p_xorLit) else $error("Xor literal wrong");

  property p_dirLoad;
    instValid && instOp == ssxa_pkg::OP_PIN_DIRECTION_LOAD && fileAddr == 7'h06 |=>
      dirB_q == $past(acc_q) && $stable(dirA_q) && $stable({carry_q, zero_q});
  endproperty
  a_dirLoad: assert property (p_dirLoad) else $error("Direction load wrong");

  property p_xorFile;
    instValid && instOp == ssxa_pkg::OP_XOR_ACC_WITH_FILE |=>
      $stable({carry_q, nib_q}) && zero_q == (($past(acc_q) ^ $past(fileRdData)) == 8'h00);
  endproperty
  a_xorFile: assert property (p_xorFile) else $error("Xor file wrong");

endmodule // ssxa_datapath

// File: tb/ssxa_file_model.sv
// Register file model that answers the datapath's read and write ports
`timescale 1ns/1ns
module ssxa_file_model (
  // Clock
  input  wire logic       core_clk,
  // Read port
  input  wire logic [6:0] fileAddr,
  output logic      [7:0] fileRdData,
  // Write port
  input  wire logic       fileWrEn,
  input  wire logic [6:0] fileWrAddr,
  input  wire logic [7:0] fileWrData
);
  logic [7:0] mem [128];
  assign fileRdData = mem[fileAddr];
  always @(posedge core_clk) begin
    if (fileWrEn) begin
      mem[fileWrAddr] <= fileWrData;
    end
  end
endmodule // ssxa_file_model

// File: tb/test_subtract_swap_xor_alu_ops.sv
// Self-checking bench for the subtract, swap, xor and direction-load datapath
`timescale 1ns/1ns
module test_subtract_swap_xor_alu_ops;
  logic               core_clk, reset_n, instValid, destBit, fileWrEn;
  logic               carryFlag, nibbleBorrowFlag, zeroFlag, c, nb, z;
  ssxa_pkg::ssxa_op_t instOp;
  logic [6:0]         fileAddr, fileWrAddr;
  logic [7:0]         literal, fileRdData, fileWrData, accOut, acc;
  logic [7:0]         portADirection, portBDirection, portCDirection;
  logic [23:0]        dirs;
  int                 failures, comparisons;

  ssxa_datapath DUT (.core_clk(core_clk), .reset_n(reset_n), .instValid(instValid), .instOp(instOp),
    .fileAddr(fileAddr), .destBit(destBit), .literal(literal), .fileRdData(fileRdData),
    .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .accOut(accOut),
    .carryFlag(carryFlag), .nibbleBorrowFlag(nibbleBorrowFlag), .zeroFlag(zeroFlag),
    .portADirection(portADirection), .portBDirection(portBDirection), .portCDirection(portCDirection));
  ssxa_file_model rf (.core_clk(core_clk), .fileAddr(fileAddr), .fileRdData(fileRdData),
    .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One instruction: expectation from own model, issue, compare
  task automatic run(input ssxa_pkg::ssxa_op_t op, input logic [6:0] a, input logic d,
                     input logic [7:0] lit, input logic [7:0] f);
    logic [8:0] r;
    logic [4:0] n;
    logic       b;
    logic       wr;
    logic       res;
    b = ~c;
    wr = 1'b0;
    res = 1'b1;
    r = 9'h000;
    case (op)
      ssxa_pkg::OP_SUBTRACT_ACC_FROM_FILE, ssxa_pkg::OP_SUBTRACT_WITH_BORROW: begin
        if (op == ssxa_pkg::OP_SUBTRACT_ACC_FROM_FILE) b = 1'b0;
        r = {1'b0, f} - {1'b0, acc} - b;
        n = {1'b0, f[3:0]} - {1'b0, acc[3:0]} - b;
        c = ~r[8];
        nb = ~n[4];
        z = (r[7:0] == 8'h00);
      end
      ssxa_pkg::OP_NIBBLE_EXCHANGE: r = {1'b0, f[3:0], f[7:4]};
      ssxa_pkg::OP_XOR_LITERAL_INTO_ACC, ssxa_pkg::OP_XOR_ACC_WITH_FILE: begin
        r = {1'b0, acc ^ ((op == ssxa_pkg::OP_XOR_LITERAL_INTO_ACC) ? lit : f)};
        z = (r[7:0] == 8'h00);
      end
      ssxa_pkg::OP_PIN_DIRECTION_LOAD: begin
        res = 1'b0;
        if (a == 7'h05) dirs[23:16] = acc;
        if (a == 7'h06) dirs[15:8] = acc;
        if (a == 7'h07) dirs[7:0] = acc;
      end
      default: res = 1'b0;
    endcase
    if (res && op != ssxa_pkg::OP_XOR_LITERAL_INTO_ACC) wr = d;
    @(posedge core_clk);
    instValid <= 1'b1;
    instOp <= op;
    fileAddr <= a;
    destBit <= d;
    literal <= lit;
    #1 rf.mem[a] = f;
    @(posedge core_clk);
    instValid <= 1'b0;
    #1;
    if (res && !wr) acc = r[7:0];
    check("acc", accOut, acc);
    check("flags", {carryFlag, nibbleBorrowFlag, zeroFlag}, {c, nb, z});
    check("dir", {portADirection, portBDirection, portCDirection}, dirs);
    check("wren", fileWrEn, wr);
    if (wr) check("write", {fileWrAddr, fileWrData}, {a, r[7:0]});
  endtask

  initial begin
    #20000;
    failures++;
    print_verdict();
  end

  initial begin
    reset_n = 1'b0;
    instValid = 1'b0;
    instOp = ssxa_pkg::OP_NONE;
    fileAddr = 7'h00;
    destBit = 1'b0;
    literal = 8'h00;
    acc = ssxa_pkg::ACC_RESET;
    {c, nb, z} = 3'h0;
    dirs = 24'hffffff;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check("reset", {accOut, carryFlag, nibbleBorrowFlag, zeroFlag, fileWrEn}, 12'h000);
    check("dirreset", {portADirection, portBDirection, portCDirection}, dirs);
    run(ssxa_pkg::OP_XOR_LITERAL_INTO_ACC, 7'h00, 1'b1, 8'h01, 8'h00);
    run(ssxa_pkg::OP_SUBTRACT_ACC_FROM_FILE, 7'h10, 1'b0, 8'h00, 8'h10);
    run(ssxa_pkg::OP_SUBTRACT_ACC_FROM_FILE, 7'h7f, 1'b1, 8'h00, 8'h01);
    run(ssxa_pkg::OP_SUBTRACT_WITH_BORROW, 7'h00, 1'b0, 8'h00, 8'h20);
    run(ssxa_pkg::OP_SUBTRACT_WITH_BORROW, 7'h01, 1'b1, 8'h00, 8'h10);
    run(ssxa_pkg::OP_SUBTRACT_ACC_FROM_FILE, 7'h02, 1'b0, 8'h00, 8'h10);
    run(ssxa_pkg::OP_NIBBLE_EXCHANGE, 7'h03, 1'b0, 8'h00, 8'ha5);
    run(ssxa_pkg::OP_NIBBLE_EXCHANGE, 7'h04, 1'b1, 8'h00, 8'h3c);
    run(ssxa_pkg::OP_XOR_ACC_WITH_FILE, 7'h05, 1'b1, 8'h00, 8'h5a);
    run(ssxa_pkg::OP_XOR_ACC_WITH_FILE, 7'h06, 1'b0, 8'h00, 8'hff);
    run(ssxa_pkg::OP_XOR_LITERAL_INTO_ACC, 7'h00, 1'b0, 8'ha5, 8'h00);
    for (int i = 4; i < 8; i++) begin
      run(ssxa_pkg::OP_XOR_LITERAL_INTO_ACC, 7'h00, 1'b0, 8'h80 | i[7:0], 8'h00);
      run(ssxa_pkg::OP_PIN_DIRECTION_LOAD, i[6:0], 1'b0, 8'h00, 8'h00);
    end
    run(ssxa_pkg::OP_NONE, 7'h08, 1'b1, 8'h00, 8'h00);
    print_verdict();
  end
endmodule // test_subtract_swap_xor_alu_ops
